/* File: src/pirq_defines.vh */
// Purpose: Constants of the peripheral interrupt enable and flag bank.
// Assumes: One register per address, eight data bits per register.
// Notes: Included by its bare name; definitions only.
`ifndef PIRQ_DEFINES_VH
`define PIRQ_DEFINES_VH

// Register bus widths.
`define PIRQ_ADDR_W 4
`define PIRQ_DATA_W 8

// Register offsets.
`define PIRQ_OFS_ENABLE_1 4'h0
`define PIRQ_OFS_ENABLE_2 4'h1
`define PIRQ_OFS_FLAG_1 4'h2
`define PIRQ_OFS_FLAG_2 4'h3
`define PIRQ_OFS_CORE_CTRL 4'h4
`define PIRQ_OFS_STATUS 4'h5
`define PIRQ_OFS_STAT_CLEAR 4'h6
`define PIRQ_OFS_STAT_ENABLE 4'h7

// Reset values.
`define PIRQ_RST_BYTE 8'h00
`define PIRQ_RST_STAT 3'h0

// Implemented bits of the second enable and flag registers.
`define PIRQ_ENABLE_2_MASK 8'hB8
// Software-writable bits of the first flag register.
`define PIRQ_FLAG_1_SW_MASK 8'hCF

// Field positions of the first enable and flag registers.
`define PIRQ_BIT_TIMER1_GATE 7
`define PIRQ_BIT_ADC_DONE 6
`define PIRQ_BIT_SERIAL_RX 5
`define PIRQ_BIT_SERIAL_TX 4
`define PIRQ_BIT_SYNC_SERIAL 3
`define PIRQ_BIT_CAPTURE_COMPARE 2
`define PIRQ_BIT_TIMER2_MATCH 1
`define PIRQ_BIT_TIMER1_OVERFLOW 0

// Field positions of the second enable and flag registers.
`define PIRQ_BIT_OSC_FAIL 7
`define PIRQ_BIT_COMPARATOR 5
`define PIRQ_BIT_EEPROM_WRITE 4
`define PIRQ_BIT_BUS_COLLISION 3

// Field positions of the core control register.
`define PIRQ_BIT_GLOBAL_EN 7
`define PIRQ_BIT_MASTER_EN 6

// Block status bits.
`define PIRQ_STAT_W 3
`define PIRQ_STAT_REQ_RISE 0
`define PIRQ_STAT_STALE_EN 1
`define PIRQ_STAT_MASKED_EVT 2

`endif

/* File: src/pirq_flag_bank.v */
// Purpose: Bank of sticky flags with load, clear and set.
// Assumes: Set, clear and load come from the same clock domain.
// Notes: A set in the same cycle as a clear or load leaves the flag set.
`timescale 1ns/1ns
`default_nettype none

module pirq_flag_bank
#(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}}
)
(
	// Clock and reset.
	input wire clock_i,
	input wire rst_i,
	// Flag controls.
	input wire [WIDTH-1:0] set_i,
	input wire [WIDTH-1:0] clr_i,
	input wire load_i,
	input wire [WIDTH-1:0] load_data_i,
	// Flag state.
	output wire [WIDTH-1:0] flags_o
);

	reg [WIDTH-1:0] flags_r;
	reg [WIDTH-1:0] flags_nxt;

	// Load or clear first, then let hardware sets win over both.
	always @*
	begin
		flags_nxt = load_i ? load_data_i : flags_r;
		flags_nxt = (flags_nxt & ~clr_i) | set_i;
		flags_nxt = flags_nxt & MASK; // Unimplemented bits stay zero.
	end

	// Flag storage, cleared by every reset.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			flags_r <= {WIDTH{1'b0}};
		else
			flags_r <= flags_nxt;
	end

	assign flags_o = flags_r;

endmodule // pirq_flag_bank

`default_nettype wire

/* File: src/pirq_bank.v */
// Purpose: Peripheral interrupt enable and flag bank with request output.
// Assumes: All inputs are synchronous to clock_i; reset covers all sources.
// Notes: Outputs are registered, so requests follow flags by one cycle.
//
// Overview of operation
// - First enable bits 7..4: timer1 gate, ADC, serial receive, transmit.
// - First enable bits 3..0: sync serial, capture, timer2 match, timer1.
// - Second enable: osc fail bit 7, comparator 5, EEPROM 4, collision 3.
// - Second enable bits 6 and 2..0 read zero and ignore writes.
// - No peripheral request unless the peripheral master enable is set.
// - Flags set on their condition regardless of any enable bit.
// - First flag register uses the first enable register bit order.
// - Serial receive and transmit flags are read-only unit status.
// - Every implemented enable and flag bit resets to zero.
// - Global enable clear holds the core request off; it fires once set.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

`include "pirq_defines.vh"

module pirq_bank
(
	// Clock and reset.
	input wire clock_i,
	input wire rst_i,
	// Register port.
	input wire [`PIRQ_ADDR_W-1:0] addr_i,
	input wire [`PIRQ_DATA_W-1:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [`PIRQ_DATA_W-1:0] rdata_o,
	// Peripheral conditions for the first flag register.
	input wire timer1_gate_evt_i,
	input wire adc_done_evt_i,
	input wire serial_rx_flag_i,
	input wire serial_tx_flag_i,
	input wire sync_serial_evt_i,
	input wire capture_compare_evt_i,
	input wire timer2_match_evt_i,
	input wire timer1_overflow_evt_i,
	// Peripheral conditions for the second flag register.
	input wire osc_fail_evt_i,
	input wire comparator_evt_i,
	input wire eeprom_write_evt_i,
	input wire bus_collision_evt_i,
	// Requests to the core.
	output reg periph_req_o,
	output reg core_irq_o,
	// Block interrupt.
	output reg irq_o
);

	// Returns high when any source is both pending and enabled.
	function pirq_any;
		input [`PIRQ_DATA_W-1:0] flags;
		input [`PIRQ_DATA_W-1:0] enables;
		begin
			pirq_any = |(flags & enables);
		end
	endfunction

	// Returns high when a strobe addresses the given offset.
	function pirq_hit;
		input strobe;
		input [`PIRQ_ADDR_W-1:0] addr;
		input [`PIRQ_ADDR_W-1:0] ofs;
		begin
			pirq_hit = strobe & (addr == ofs);
		end
	endfunction

	reg [`PIRQ_DATA_W-1:0] enable_1_r;
	reg [`PIRQ_DATA_W-1:0] enable_2_r;
	reg global_en_r;
	reg master_en_r;
	reg serial_rx_r;
	reg serial_tx_r;
	reg [`PIRQ_STAT_W-1:0] stat_en_r;
	reg [`PIRQ_DATA_W-1:0] rdata_nxt;
	reg [`PIRQ_DATA_W-1:0] set_1;
	reg [`PIRQ_DATA_W-1:0] set_2;
	reg [`PIRQ_DATA_W-1:0] flag_1_view;
	reg [`PIRQ_STAT_W-1:0] stat_set;
	reg periph_req_nxt;
	reg irq_nxt;
	wire [`PIRQ_DATA_W-1:0] flag_1_sw;
	wire [`PIRQ_DATA_W-1:0] flag_2;
	wire [`PIRQ_STAT_W-1:0] status;
	wire [`PIRQ_STAT_W-1:0] stat_next_view;
	wire wr_en_1;
	wire wr_en_2;
	wire wr_flag_1;
	wire wr_flag_2;
	wire wr_ctrl;
	wire wr_stat_clr;
	wire wr_stat_en;

	// Write decode. The status offset has no decode, so writes to it are
	// dropped without effect.
	assign wr_en_1 = pirq_hit(wr_i, addr_i, `PIRQ_OFS_ENABLE_1);
	assign wr_en_2 = pirq_hit(wr_i, addr_i, `PIRQ_OFS_ENABLE_2);
	assign wr_flag_1 = pirq_hit(wr_i, addr_i, `PIRQ_OFS_FLAG_1);
	assign wr_flag_2 = pirq_hit(wr_i, addr_i, `PIRQ_OFS_FLAG_2);
	assign wr_ctrl = pirq_hit(wr_i, addr_i, `PIRQ_OFS_CORE_CTRL);
	assign wr_stat_clr = pirq_hit(wr_i, addr_i, `PIRQ_OFS_STAT_CLEAR);
	assign wr_stat_en = pirq_hit(wr_i, addr_i, `PIRQ_OFS_STAT_ENABLE);

	// Enable registers, the second one holding only its implemented bits.
	// Setting an enable over a pending flag is reported as a stale enable.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			enable_1_r <= `PIRQ_RST_BYTE;
			enable_2_r <= `PIRQ_RST_BYTE;
		end
		else
		begin
			if (wr_en_1)
				enable_1_r <= wdata_i;
			if (wr_en_2)
				enable_2_r <= wdata_i & `PIRQ_ENABLE_2_MASK;
		end
	end

	// Core control bits: global enable and peripheral master enable.
	// Clearing the global enable only holds the core request off; flags and
	// the peripheral request keep their state, so nothing pending is lost.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			global_en_r <= 1'b0;
			master_en_r <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			global_en_r <= wdata_i[`PIRQ_BIT_GLOBAL_EN];
			master_en_r <= wdata_i[`PIRQ_BIT_MASTER_EN];
		end
	end

	// Serial unit status is sampled, never written by software.
	// The flag load masks these bits, so a write cannot touch them.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			serial_rx_r <= 1'b0;
			serial_tx_r <= 1'b0;
		end
		else
		begin
			serial_rx_r <= serial_rx_flag_i;
			serial_tx_r <= serial_tx_flag_i;
		end
	end

	// Hardware set vectors, independent of every enable bit.
	// Serial bits stay zero here; they join the flags in the read view.
	always @*
	begin
		set_1 = `PIRQ_RST_BYTE;
		set_1[`PIRQ_BIT_TIMER1_GATE] = timer1_gate_evt_i;
		set_1[`PIRQ_BIT_ADC_DONE] = adc_done_evt_i;
		set_1[`PIRQ_BIT_SYNC_SERIAL] = sync_serial_evt_i;
		set_1[`PIRQ_BIT_CAPTURE_COMPARE] = capture_compare_evt_i;
		set_1[`PIRQ_BIT_TIMER2_MATCH] = timer2_match_evt_i;
		set_1[`PIRQ_BIT_TIMER1_OVERFLOW] = timer1_overflow_evt_i;
		set_2 = `PIRQ_RST_BYTE;
		set_2[`PIRQ_BIT_OSC_FAIL] = osc_fail_evt_i;
		set_2[`PIRQ_BIT_COMPARATOR] = comparator_evt_i;
		set_2[`PIRQ_BIT_EEPROM_WRITE] = eeprom_write_evt_i;
		set_2[`PIRQ_BIT_BUS_COLLISION] = bus_collision_evt_i;
	end

	// Software-writable part of the first flag register.
	pirq_flag_bank
	#(
		.WIDTH(`PIRQ_DATA_W),
		.MASK(`PIRQ_FLAG_1_SW_MASK)
	)
	u_flag_1
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.set_i(set_1),
		.clr_i(`PIRQ_RST_BYTE),
		.load_i(wr_flag_1),
		.load_data_i(wdata_i),
		.flags_o(flag_1_sw)
	);

	// Flags of the four sources enabled by the second enable register.
	pirq_flag_bank
	#(
		.WIDTH(`PIRQ_DATA_W),
		.MASK(`PIRQ_ENABLE_2_MASK)
	)
	u_flag_2
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.set_i(set_2),
		.clr_i(`PIRQ_RST_BYTE),
		.load_i(wr_flag_2),
		.load_data_i(wdata_i),
		.flags_o(flag_2)
	);

	// Full view of the first flag register with the serial status merged.
	always @*
	begin
		flag_1_view = flag_1_sw;
		flag_1_view[`PIRQ_BIT_SERIAL_RX] = serial_rx_r;
		flag_1_view[`PIRQ_BIT_SERIAL_TX] = serial_tx_r;
	end

	// Combined request: any pending enabled source, gated by the master.
	always @*
	begin
		periph_req_nxt = master_en_r &
			(pirq_any(flag_1_view, enable_1_r) |
			pirq_any(flag_2, enable_2_r));
	end

	// Request registers; pending flags stay held while the global is off.
	// Both derive from periph_req_nxt, the core one gated by global_en_r, so the core request never leads.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			periph_req_o <= 1'b0;
			core_irq_o <= 1'b0;
		end
		else
		begin
			periph_req_o <= periph_req_nxt;
			core_irq_o <= global_en_r & periph_req_nxt;
		end
	end

	// Block events: request rising, enable set over a pending flag, and a
	// condition other than serial status that arrives while its source is disabled.
	always @*
	begin
		stat_set = `PIRQ_RST_STAT;
		stat_set[`PIRQ_STAT_REQ_RISE] = periph_req_nxt & ~periph_req_o;
		stat_set[`PIRQ_STAT_STALE_EN] =
			(wr_en_1 & (|(wdata_i & ~enable_1_r & flag_1_view))) |
			(wr_en_2 & (|(wdata_i & ~enable_2_r & flag_2)));
		stat_set[`PIRQ_STAT_MASKED_EVT] =
			(|(set_1 & ~enable_1_r)) | (|(set_2 & ~enable_2_r));
	end

	// Sticky status; write one to the clear register to drop a bit.
	pirq_flag_bank
	#(
		.WIDTH(`PIRQ_STAT_W)
	)
	u_status
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.set_i(stat_set),
		.clr_i(wr_stat_clr ? wdata_i[`PIRQ_STAT_W-1:0] : `PIRQ_RST_STAT),
		.load_i(1'b0),
		.load_data_i(`PIRQ_RST_STAT),
		.flags_o(status)
	);

	// Status value one cycle ahead, so the interrupt leaves a flip-flop.
	// It repeats the update of the status bank, so irq_o adds no cycle.
	assign stat_next_view = (status &
		~(wr_stat_clr ? wdata_i[`PIRQ_STAT_W-1:0] : `PIRQ_RST_STAT)) |
		stat_set;

	// Status enable register.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			stat_en_r <= `PIRQ_RST_STAT;
		else if (wr_stat_en)
			stat_en_r <= wdata_i[`PIRQ_STAT_W-1:0];
	end

	// Interrupt level follows the next status and next enable.
	always @*
	begin
		irq_nxt = |(stat_next_view &
			(wr_stat_en ? wdata_i[`PIRQ_STAT_W-1:0] : stat_en_r));
	end

	// Block interrupt register; high while an enabled status bit is set.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= irq_nxt;
	end

	// Read multiplexer; unmapped and write-only offsets read zero.
	// Reads have no side effect, so polling never loses an event.
	always @*
	begin
		rdata_nxt = `PIRQ_RST_BYTE;
		if (rd_i)
		begin
			case (addr_i)
				`PIRQ_OFS_ENABLE_1: rdata_nxt = enable_1_r;
				`PIRQ_OFS_ENABLE_2: rdata_nxt = enable_2_r;
				`PIRQ_OFS_FLAG_1: rdata_nxt = flag_1_view;
				`PIRQ_OFS_FLAG_2: rdata_nxt = flag_2;
				`PIRQ_OFS_CORE_CTRL:
				begin
					rdata_nxt[`PIRQ_BIT_GLOBAL_EN] = global_en_r;
					rdata_nxt[`PIRQ_BIT_MASTER_EN] = master_en_r;
				end
				`PIRQ_OFS_STATUS:
					rdata_nxt[`PIRQ_STAT_W-1:0] = status;
				`PIRQ_OFS_STAT_ENABLE:
					rdata_nxt[`PIRQ_STAT_W-1:0] = stat_en_r;
				default: rdata_nxt = `PIRQ_RST_BYTE;
			endcase
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= `PIRQ_RST_BYTE;
		else
			rdata_o <= rdata_nxt;
	end

endmodule // pirq_bank

`default_nettype wire

/* File: tb/pirq_bank_asserts.sv */
// Purpose: Port checker for the interrupt enable and flag bank.
// Assumes: Sees only the ports of pirq_bank.
// Notes: Bound to every bank instance.
`timescale 1ns/1ns
`default_nettype none
module pirq_bank_asserts
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [3:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Sources.
	input wire logic serial_rx_flag_i,
	input wire logic serial_tx_flag_i,
	input wire logic timer1_gate_evt_i,
	input wire logic timer1_overflow_evt_i,
	input wire logic osc_fail_evt_i,
	// Requests.
	input wire logic periph_req_o,
	input wire logic core_irq_o,
	input wire logic irq_o
);
	// Checks run on the bank clock and, except rst_quiet_a, pause in reset.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// Register reads and requests.
	rst_quiet_a: assert property (disable iff (1'b0) rst_i |->
		!periph_req_o && !core_irq_o && !irq_o && rdata_o == 8'h00)
		else $error("output active in reset");
	en2_zero_a: assert property (rd_i && addr_i == 4'h1 |=>
		(rdata_o & 8'h47) == 8'h00) else $error("enable2 spare bit set");
	flag2_zero_a: assert property (rd_i && addr_i == 4'h3 |=>
		(rdata_o & 8'h47) == 8'h00) else $error("flag2 spare bit set");
	rx_copy_a: assert property (rd_i && addr_i == 4'h2 && !$past(rst_i)
		|=> rdata_o[5] == $past(serial_rx_flag_i, 2))
		else $error("rx flag differs from unit");
	tx_copy_a: assert property (rd_i && addr_i == 4'h2 && !$past(rst_i)
		|=> rdata_o[4] == $past(serial_tx_flag_i, 2))
		else $error("tx flag differs from unit");
	t1_flag_a: assert property (timer1_overflow_evt_i ##1
		(rd_i && addr_i == 4'h2) |=> rdata_o[0]) else $error("t1 flag lost");
	gate_flag_a: assert property (timer1_gate_evt_i ##1
		(rd_i && addr_i == 4'h2) |=> rdata_o[7]) else $error("gate flag lost");
	osc_flag_a: assert property (osc_fail_evt_i ##1
		(rd_i && addr_i == 4'h3) |=> rdata_o[7]) else $error("osc flag lost");
	// Main scenarios reached.
	req_c: cover property (periph_req_o);
	core_c: cover property (core_irq_o);
	irq_c: cover property (irq_o);
endmodule // pirq_bank_asserts
bind pirq_bank pirq_bank_asserts chk (.clock_i(clock_i), .rst_i(rst_i),
	.addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.serial_rx_flag_i(serial_rx_flag_i), .serial_tx_flag_i(serial_tx_flag_i),
	.timer1_gate_evt_i(timer1_gate_evt_i), .osc_fail_evt_i(osc_fail_evt_i),
	.timer1_overflow_evt_i(timer1_overflow_evt_i),
	.periph_req_o(periph_req_o), .core_irq_o(core_irq_o), .irq_o(irq_o));
`default_nettype wire

/* File: tb/pirq_periph_model.sv */
// Purpose: Peripheral sources that raise the bank's conditions.
// Assumes: Commands change just after a rising edge.
// Notes: Events last one cycle; serial status is a held level.
`timescale 1ns/1ns
`default_nettype none
module pirq_periph_model
(
	// Clock.
	input wire logic clock_i,
	// Commands.
	input wire logic [11:0] fire_i,
	input wire logic rx_i,
	input wire logic tx_i,
	// Source lines.
	output logic [11:0] evt_o,
	output logic rx_o,
	output logic tx_o
);
	// Conditions fire whatever the enables hold.
	always @(posedge clock_i)
	begin
		evt_o <= fire_i;
		rx_o <= rx_i;
		tx_o <= tx_i;
	end
endmodule // pirq_periph_model
`default_nettype wire

/* File: tb/test_pirq_bank.sv */
// Purpose: Self-checking bench of the enable and flag bank.
// Assumes: Offsets 0..7 as set in the bank's defines.
// Notes: Requests are sampled two edges after their cause.
`timescale 1ns/1ns
`default_nettype none
module test_pirq_bank;
	logic clock_i = 1'b0;
	logic rst_i = 1'b0;
	logic [3:0] addr_r = 4'h0;
	logic [7:0] wdata_r = 8'h00;
	logic wr_r = 1'b0;
	logic rd_r = 1'b0;
	logic [11:0] fire_r = 12'h000;
	logic rx_r = 1'b0;
	logic tx_r = 1'b0;
	wire [7:0] rdata;
	wire [11:0] evt;
	wire rx, tx, preq, creq, irq;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	// Clock of 8 ns.
	always #4 clock_i = ~clock_i;
	// Peripheral sources.
	pirq_periph_model src (.clock_i(clock_i), .fire_i(fire_r), .rx_i(rx_r),
		.tx_i(tx_r), .evt_o(evt), .rx_o(rx), .tx_o(tx));
	// Block under test.
	pirq_bank DUT (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_r),
		.wdata_i(wdata_r), .wr_i(wr_r), .rd_i(rd_r), .rdata_o(rdata),
		.timer1_gate_evt_i(evt[7]), .adc_done_evt_i(evt[6]),
		.serial_rx_flag_i(rx), .serial_tx_flag_i(tx),
		.sync_serial_evt_i(evt[3]), .capture_compare_evt_i(evt[2]),
		.timer2_match_evt_i(evt[1]), .timer1_overflow_evt_i(evt[0]),
		.osc_fail_evt_i(evt[11]), .comparator_evt_i(evt[10]),
		.eeprom_write_evt_i(evt[9]), .bus_collision_evt_i(evt[8]),
		.periph_req_o(preq), .core_irq_o(creq), .irq_o(irq));
	task report_and_stop;
	begin
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
	begin
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge clock_i);
		addr_r <= a;
		wdata_r <= d;
		wr_r <= 1'b1;
		@(posedge clock_i);
		wr_r <= 1'b0;
	end
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
	begin
		@(posedge clock_i);
		addr_r <= a;
		rd_r <= 1'b1;
		@(posedge clock_i);
		rd_r <= 1'b0;
		#1 chk8(rdata, exp);
	end
	endtask
	task fire(input logic [11:0] f);
	begin
		@(posedge clock_i);
		fire_r <= f;
		@(posedge clock_i);
		fire_r <= 12'h000;
	end
	endtask
	// Compares periph_req_o, core_irq_o and irq_o.
	task outs(input logic [2:0] exp);
	begin
		repeat (2) @(posedge clock_i);
		#1 chk8({5'h00, preq, creq, irq}, {5'h00, exp});
	end
	endtask
	task t_reset;
	begin
		for (int i = 0; i < 8; i++)
			rd(i[3:0], 8'h00);
		rd(4'hf, 8'h00);
	end
	endtask
	task t_enables;
	begin
		wr(4'h0, 8'hff);
		rd(4'h0, 8'hff);
		wr(4'h1, 8'hff);
		rd(4'h1, 8'hb8);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h00);
	end
	endtask
	task t_flags;
	begin
		fire(12'hfff);
		rd(4'h2, 8'hcf);
		rd(4'h3, 8'hb8);
		outs(3'b000);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h00);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'hcf);
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		wr(4'h6, 8'h07);
	end
	endtask
	task t_master;
	begin
		fire(12'h001);
		wr(4'h0, 8'h01);
		rd(4'h5, 8'h06);
		outs(3'b000);
		wr(4'h4, 8'h40);
		outs(3'b100);
		wr(4'h4, 8'hc0);
		outs(3'b110);
		wr(4'h2, 8'h00);
		outs(3'b000);
		wr(4'h7, 8'h07);
		outs(3'b001);
		wr(4'h6, 8'h07);
		outs(3'b000);
		fire(12'h001);
		outs(3'b111);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h80);
		fire(12'h800);
		rd(4'h3, 8'h80);
		wr(4'h1, 8'h80);
		outs(3'b111);
		wr(4'h3, 8'h00);
		wr(4'h7, 8'h00);
	end
	endtask
	task t_serial;
	begin
		@(posedge clock_i);
		rx_r <= 1'b1;
		repeat (2) @(posedge clock_i);
		rd(4'h2, 8'h20);
		wr(4'h0, 8'h20);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h20);
		outs(3'b110);
		@(posedge clock_i);
		rx_r <= 1'b0;
		tx_r <= 1'b1;
		repeat (2) @(posedge clock_i);
		rd(4'h2, 8'h10);
		@(posedge clock_i);
		tx_r <= 1'b0;
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(4'h0, 8'h00);
		rd(4'h4, 8'h00);
	end
	endtask
	// Cuts a hung run short.
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			fails++;
			report_and_stop;
		end
	end
	// Main sequence.
	initial
	begin
		// Reset rises at time zero, so outputs are known at the first edge.
		rst_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset;
		t_enables;
		t_flags;
		t_master;
		t_serial;
		report_and_stop;
	end
endmodule // test_pirq_bank
`default_nettype wire
